// File: src/pptu_core.sv
`timescale 1ns/10ps
`include "pptu_regs.svh"

module pptu_core #(
   parameter int SEC_CYC = `PPTU_SEC_CYC,
   parameter int BEEP_CYC = `PPTU_BEEP_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Phase execution from the sequencer
   input wire logic cmd_valid,
   input wire pptu_pkg::pptu_cmd_type cmd,
   input wire logic [`PPTU_PHASE_W-1:0] cur_phase,
   output logic cmd_ready,
   output pptu_pkg::pptu_step_type step,
   // Run state and options
   input wire logic run_active,
   input wire logic alarm_en,
   // Keypad and serial events, one cycle pulses
   input wire logic start_key,
   input wire logic other_key,
   input wire logic serial_start,
   input wire logic serial_event_run,
   // TTL pins
   input wire logic event_pin,
   input wire logic prog_in_pin,
   input wire logic ttl_start_pin,
   output logic prog_out,
   // Trap and program control
   output logic trap_fire,
   output logic [`PPTU_PHASE_W-1:0] fire_target,
   output logic trap_armed,
   output logic prog_stop,
   output logic pump_hold,
   output logic buzzer
);

   typedef enum logic [1:0] {
      st_idle,
      st_pause,
      st_wait,
      st_beep
   } pptu_state_type;

   localparam logic [`PPTU_TICK_W-1:0] SEC_LAST =
      `PPTU_TICK_W'(SEC_CYC - 1);
   localparam logic [`PPTU_TICK_W-1:0] BEEP_LAST =
      `PPTU_TICK_W'(BEEP_CYC - 1);

   function automatic logic [`PPTU_PHASE_W-1:0] inc_phase(
      input logic [`PPTU_PHASE_W-1:0] p);
      inc_phase = p + `PPTU_PHASE_W'(1);
   endfunction

   pptu_state_type state;
   pptu_state_type next_state;
   logic [`PPTU_PIN_N-1:0] pin_lvl;
   logic ev_prev;
   logic start_prev;
   logic trap_edge;
   logic [`PPTU_PHASE_W-1:0] trap_target;
   logic [`PPTU_PHASE_W-1:0] seq_phase;
   logic [`PPTU_PHASE_W-1:0] sec_left;
   logic [`PPTU_TICK_W-1:0] tick;
   logic next_trap_armed;
   logic next_buzzer;
   pptu_pkg::pptu_step_type next_step;

   wire ev_lvl = pin_lvl[`PPTU_PIN_EVENT];
   wire prog_lvl = pin_lvl[`PPTU_PIN_PROG];
   wire start_lvl = pin_lvl[`PPTU_PIN_START];
   wire ev_fall = ev_prev & ~ev_lvl;
   wire ev_rise = ~ev_prev & ev_lvl;
   wire ttl_start = start_prev & ~start_lvl;

   pptu_sync u_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_raw({ttl_start_pin, prog_in_pin, event_pin}),
      .pin_lvl(pin_lvl)
   );

   // Trap triggers
   wire trig_hit = serial_event_run |
      (trap_edge ? (ev_rise | ev_fall) : ev_fall);
   wire fire_now = trap_armed & run_active & trig_hit;
   assign cmd_ready = (state == st_idle) & ~fire_now;
   wire accept = cmd_valid & cmd_ready;
   wire acc_pause = accept & (cmd.op == pptu_pkg::pause_phase);
   wire acc_cond = accept & (cmd.op == pptu_pkg::conditional_jump_phase);
   wire acc_level = accept & (cmd.op == pptu_pkg::level_trap_setup);
   wire acc_edge = accept & (cmd.op == pptu_pkg::edge_trap_setup);
   wire acc_cancel = accept & (cmd.op == pptu_pkg::trap_cancel);
   wire acc_out = accept & (cmd.op == pptu_pkg::output_set_phase);
   wire acc_beep = accept & (cmd.op == pptu_pkg::beep_phase);
   wire acc_jump = accept & (cmd.op == pptu_pkg::jump_phase);
   wire setup_fire = acc_level & ~ev_lvl;
   wire any_fire = fire_now | setup_fire;
   wire start_trig = start_key | ttl_start | serial_start;
   wire waiting = state == st_wait;
   // Any start source wins over a stray key in the same cycle
   wire key_stop = waiting & other_key & ~start_trig & ~fire_now;
   wire tick_end = (state == st_pause) & (tick == SEC_LAST);
   wire beep_end = (state == st_beep) & (tick == BEEP_LAST);
   wire pause_end = tick_end & (sec_left == `PPTU_PHASE_W'(1));
   wire wait_end = waiting & start_trig & ~fire_now;

   // Firing and stopping drop the trap; a fresh setup replaces it
   assign next_trap_armed = (any_fire | ~run_active | acc_cancel | key_stop)
      ? 1'b0 : ((acc_level | acc_edge) ? 1'b1 : trap_armed);

   always_comb begin
      next_state = state;
      if (any_fire | key_stop | ~run_active) begin
         next_state = st_idle;
      end else if (acc_pause) begin
         next_state = (cmd.arg == `PPTU_PAUSE_WAIT) ? st_wait : st_pause;
      end else if (acc_beep) begin
         next_state = st_beep;
      end else if (pause_end | wait_end | beep_end) begin
         next_state = st_idle;
      end
   end

   always_comb begin
      next_step.valid = 1'b0;
      next_step.phase = seq_phase;
      if (any_fire | key_stop | ~run_active) begin
         next_step.valid = 1'b0;
      end else if (acc_cond) begin
         next_step.valid = 1'b1;
         next_step.phase = prog_lvl ? inc_phase(cur_phase) : cmd.arg;
      end else if (acc_jump) begin
         next_step.valid = 1'b1;
         next_step.phase = cmd.arg;
      end else if (acc_edge | acc_level | acc_cancel | acc_out) begin
         next_step.valid = 1'b1;
         next_step.phase = inc_phase(cur_phase);
      end else if (pause_end | wait_end | beep_end) begin
         next_step.valid = 1'b1;
         next_step.phase = seq_phase;
      end
   end

   assign next_buzzer = ((next_state == st_wait) & alarm_en) |
      (next_state == st_beep);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= st_idle;
         step <= '0;
         buzzer <= 1'b0;
         pump_hold <= 1'b0;
         prog_stop <= 1'b0;
         ev_prev <= `PPTU_PIN_IDLE;
         start_prev <= `PPTU_PIN_IDLE;
      end else begin
         state <= next_state;
         step <= next_step;
         buzzer <= next_buzzer;
         pump_hold <= (next_state == st_pause) | (next_state == st_wait);
         prog_stop <= key_stop;
         ev_prev <= ev_lvl;
         start_prev <= start_lvl;
      end
   end

   // Trap storage
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         trap_armed <= 1'b0;
         trap_edge <= 1'b0;
         trap_target <= '0;
      end else begin
         trap_armed <= next_trap_armed;
         if (acc_level | acc_edge) begin
            trap_edge <= acc_edge;
            trap_target <= cmd.arg;
         end
      end
   end

   // Fire pulse and target for the sequencer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         trap_fire <= 1'b0;
         fire_target <= '0;
      end else begin
         trap_fire <= any_fire;
         if (any_fire) begin
            fire_target <= fire_now ? trap_target : cmd.arg;
         end
      end
   end

   // Program output pin, low after reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prog_out <= `PPTU_OUT_LOW;
      end else if (acc_out) begin
         prog_out <= cmd.arg[0];
      end
   end

   // Pause and beep timing; one tick counter serves both
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick <= '0;
         sec_left <= '0;
         seq_phase <= '0;
      end else begin
         if (accept) begin
            seq_phase <= inc_phase(cur_phase);
            sec_left <= cmd.arg;
         end else if (tick_end) begin
            sec_left <= sec_left - `PPTU_PHASE_W'(1);
         end
         if (accept | tick_end | beep_end) begin
            tick <= '0;
         end else begin
            tick <= tick + `PPTU_TICK_W'(1);
         end
      end
   end

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   sequence wait_entered;
      acc_pause && cmd.arg == `PPTU_PAUSE_WAIT && !setup_fire
         && run_active ##1 state == st_wait;
   endsequence

   sequence start_seen;
      waiting && start_trig && !fire_now && run_active;
   endsequence

   wait_holds_pump_a: assert property (
      wait_entered |-> pump_hold)
      else $error("Pump not held while waiting for start");

   start_advance_a: assert property (
      start_seen |=> step.valid && step.phase == $past(seq_phase)
         && state == st_idle)
      else $error("Start trigger did not advance phase");

   key_stop_a: assert property (
      waiting && other_key && !start_trig && !fire_now |=>
         prog_stop && state == st_idle && !trap_armed)
      else $error("Other key did not stop program");

   wait_buzzer_a: assert property (
      waiting && $past(alarm_en) |-> buzzer)
      else $error("Buzzer silent while waiting");

   cond_jump_a: assert property (
      acc_cond && !prog_lvl && run_active |=>
         step.valid && step.phase == $past(cmd.arg))
      else $error("Conditional jump not taken on low input");

   level_fall_a: assert property (
      trap_armed && !trap_edge && run_active && ev_fall |=>
         trap_fire && fire_target == $past(trap_target))
      else $error("Level trap missed falling edge");

   level_now_a: assert property (
      acc_level && !ev_lvl |=> trap_fire
         && fire_target == $past(cmd.arg) && !trap_armed)
      else $error("Level trap missed low level at setup");

   fire_abort_a: assert property (
      fire_now |=> state == st_idle && !step.valid && !buzzer)
      else $error("Trap fire did not abort phase");

   fire_disarm_a: assert property (
      trap_fire |-> !trap_armed)
      else $error("Trap still armed after firing");

   edge_rise_a: assert property (
      trap_armed && trap_edge && run_active && ev_rise |=> trap_fire)
      else $error("Edge trap missed rising edge");

   cancel_disarm_a: assert property (
      acc_cancel |=> !trap_armed)
      else $error("Cancel left trap armed");

   out_set_a: assert property (
      acc_out |=> prog_out == $past(cmd.arg[0]))
      else $error("Program output not set");

   beep_short_a: assert property (
      acc_beep && run_active |=> buzzer && state == st_beep)
      else $error("Beep did not sound");

endmodule

// File: src/pptu_pkg.sv
`include "pptu_regs.svh"

package pptu_pkg;

   typedef enum logic [2:0] {
      pause_phase,
      conditional_jump_phase,
      level_trap_setup,
      edge_trap_setup,
      trap_cancel,
      output_set_phase,
      beep_phase,
      jump_phase
   } pptu_op_type;

   typedef struct packed {
      pptu_op_type op;
      logic [`PPTU_PHASE_W-1:0] arg;
   } pptu_cmd_type;

   typedef struct packed {
      logic valid;
      logic [`PPTU_PHASE_W-1:0] phase;
   } pptu_step_type;

endpackage

// File: src/pptu_regs.svh
`ifndef PPTU_REGS_SVH
`define PPTU_REGS_SVH

// Phase numbers 1 to 99 and pause arguments 0 to 99
`define PPTU_PHASE_W 7
// Pause argument that means wait for a start trigger
`define PPTU_PAUSE_WAIT 7'h00
// Output-set argument levels
`define PPTU_OUT_LOW 1'b0
`define PPTU_OUT_HIGH 1'b1
// Clock period and times, in ns
`define PPTU_CLK_NS 100
`define PPTU_SEC_NS 1000000000
`define PPTU_BEEP_NS 100000000
// Cycle counts derived from the times
`define PPTU_SEC_CYC (`PPTU_SEC_NS / `PPTU_CLK_NS)
`define PPTU_BEEP_CYC (`PPTU_BEEP_NS / `PPTU_CLK_NS)
// Tick counter width, enough for one second
`define PPTU_TICK_W 24
// Idle level of the TTL pins after reset
`define PPTU_PIN_IDLE 1'b1
// Synchronised pin positions
`define PPTU_PIN_EVENT 0
`define PPTU_PIN_PROG 1
`define PPTU_PIN_START 2
`define PPTU_PIN_N 3

`endif

// File: src/pptu_sync.sv
`timescale 1ns/10ps
`include "pptu_regs.svh"

module pptu_sync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Raw pins
   input wire logic [`PPTU_PIN_N-1:0] pin_raw,
   // Filtered levels
   output logic [`PPTU_PIN_N-1:0] pin_lvl
);

   logic [`PPTU_PIN_N-1:0] stage1;
   logic [`PPTU_PIN_N-1:0] stage2;
   logic [`PPTU_PIN_N-1:0] stage3;
   logic [`PPTU_PIN_N-1:0] agree;
   logic [`PPTU_PIN_N-1:0] next_pin_lvl;

   // Stage one feeds only stage two, so metastability stays contained
   assign agree = ~(stage2 ^ stage3);
   assign next_pin_lvl = (agree & stage3) | (~agree & pin_lvl);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= {`PPTU_PIN_N{`PPTU_PIN_IDLE}};
         stage2 <= {`PPTU_PIN_N{`PPTU_PIN_IDLE}};
         stage3 <= {`PPTU_PIN_N{`PPTU_PIN_IDLE}};
         pin_lvl <= {`PPTU_PIN_N{`PPTU_PIN_IDLE}};
      end else begin
         stage1 <= pin_raw;
         stage2 <= stage1;
         stage3 <= stage2;
         pin_lvl <= next_pin_lvl;
      end
   end

endmodule

// File: verif/pptu_far_model.sv
`timescale 1ns/10ps
module pptu_far_model (
   // Clock
   input wire logic core_clk,
   // Keypad and serial pulses
   output logic start_key,
   output logic other_key,
   output logic serial_start,
   output logic serial_event_run,
   // TTL pins, idle high
   output logic event_pin,
   output logic prog_in_pin,
   output logic ttl_start_pin
);
   logic [3:0] pulse = 4'h0;
   logic [2:0] lvl = 3'h7;
   assign {serial_event_run, serial_start, other_key, start_key} = pulse;
   assign {ttl_start_pin, prog_in_pin, event_pin} = lvl;
   // One clock wide, as a decoded key or serial command would be
   task automatic key(input int i);
      pulse[i] = 1'b1;
      @(posedge core_clk);
      #1;
      pulse[i] = 1'b0;
   endtask
   // Pins are slow TTL levels, no glitches modelled
   task automatic pin(input int i, input logic v);
      lvl[i] = v;
   endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/10ps
`include "pptu_regs.svh"
module testbench;
   localparam int SEC = 20;
   localparam int BEEP = 5;
   logic core_clk, rstn, cmd_valid, cmd_ready, run_active, alarm_en;
   logic start_key, other_key, serial_start, serial_event_run;
   logic event_pin, prog_in_pin, ttl_start_pin, prog_out;
   logic trap_fire, trap_armed, prog_stop, pump_hold, buzzer;
   logic [`PPTU_PHASE_W-1:0] cur_phase, fire_target;
   pptu_pkg::pptu_cmd_type cmd;
   pptu_pkg::pptu_step_type step;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;

   pptu_core #(.SEC_CYC(SEC), .BEEP_CYC(BEEP)) dut_u (.core_clk, .rstn,
      .cmd_valid, .cmd, .cur_phase, .cmd_ready, .step, .run_active,
      .alarm_en, .start_key, .other_key, .serial_start, .serial_event_run,
      .event_pin, .prog_in_pin, .ttl_start_pin, .prog_out, .trap_fire,
      .fire_target, .trap_armed, .prog_stop, .pump_hold, .buzzer);
   pptu_far_model far_u (.core_clk, .start_key, .other_key, .serial_start,
      .serial_event_run, .event_pin, .prog_in_pin, .ttl_start_pin);

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard, well above the longest sequence below
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   // Request held until the edge that samples ready high
   // A free edge first, so cmd_valid is never written twice in one step
   // A refused request waits; the hang guard bounds the wait
   task automatic exec(input pptu_pkg::pptu_op_type op,
                       input logic [6:0] arg, input logic [6:0] cur);
      cyc(1);
      cmd.op = op;
      cmd.arg = arg;
      cur_phase = cur;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) begin
         cyc(1);
      end
      cyc(1);
      cmd_valid = 1'b0;
   endtask

   // Cycles until the chosen pulse, the current one counted as 1
   // Pulses launched by the accept edge are already visible on return
   task automatic ws(input int sel, input int lim, output int cnt);
      logic hit;
      cnt = 0;
      hit = 1'b0;
      while (!hit && cnt < lim) begin
         if (cnt > 0) cyc(1);
         cnt++;
         hit = (sel == 0 ? step.valid : sel == 1 ? trap_fire : prog_stop)
               === 1'b1;
      end
   endtask

   task automatic t_jumps;
      exec(pptu_pkg::jump_phase, 7'h05, 7'h01);
      ws(0, 10, n);
      chk(16'(n), 16'h0001);
      chk(16'(step.phase), 16'h0005);
      for (int i = 0; i < 2; i++) begin
         far_u.pin(1, 1'(i));
         cyc(6);
         exec(pptu_pkg::conditional_jump_phase, 7'h09, 7'h02);
         ws(0, 10, n);
         chk(16'(step.phase), i == 0 ? 16'h0009 : 16'h0003);
      end
   endtask

   task automatic t_out_beep_pause;
      for (int i = 1; i >= 0; i--) begin
         exec(pptu_pkg::output_set_phase, 7'(i), 7'h03);
         ws(0, 10, n);
         chk(16'(prog_out), 16'(i));
      end
      exec(pptu_pkg::beep_phase, 7'h00, 7'h04);
      cyc(1);
      chk(16'(buzzer), 16'h0001);
      ws(0, 50, n);
      chk(16'(n + 1), 16'(BEEP + 1));
      chk(16'(step.phase), 16'h0005);
      cyc(1);
      chk(16'(buzzer), 16'h0000);
      exec(pptu_pkg::pause_phase, 7'h02, 7'h05);
      cyc(1);
      chk(16'(pump_hold), 16'h0001);
      chk(16'(cmd_ready), 16'h0000);
      ws(0, 100, n);
      chk(16'(n + 1), 16'(2 * SEC + 1));
      chk(16'(step.phase), 16'h0006);
   endtask

   // Each start source in turn, alarms off for the TTL one
   task automatic t_wait;
      for (int s = 0; s < 3; s++) begin
         alarm_en = s != 1;
         exec(pptu_pkg::pause_phase, 7'h00, 7'h06);
         cyc(3);
         chk(16'(pump_hold), 16'h0001);
         chk(16'(buzzer), 16'(s != 1));
         if (s == 0) far_u.key(0);
         else if (s == 1) far_u.pin(2, 1'b0);
         else far_u.key(2);
         ws(0, 20, n);
         chk(16'(step.phase), 16'h0007);
         chk(16'(pump_hold), 16'h0000);
         chk(16'(buzzer), 16'h0000);
         far_u.pin(2, 1'b1);
         cyc(6);
      end
      exec(pptu_pkg::pause_phase, 7'h00, 7'h06);
      cyc(2);
      far_u.key(1);
      ws(2, 20, n);
      chk(16'(n < 20), 16'h0001);
      chk(16'(step.valid), 16'h0000);
   endtask

   task automatic t_level;
      exec(pptu_pkg::level_trap_setup, 7'h14, 7'h07);
      ws(0, 5, n);
      chk(16'(trap_armed), 16'h0001);
      exec(pptu_pkg::pause_phase, 7'h02, 7'h08);
      cyc(3);
      far_u.pin(0, 1'b0);
      ws(1, 12, n);
      chk(16'(n < 12), 16'h0001);
      chk(16'(fire_target), 16'h0014);
      chk(16'(trap_armed), 16'h0000);
      ws(0, 60, n);
      chk(16'(n), 16'h003C);
      chk(16'(cmd_ready), 16'h0001);
      exec(pptu_pkg::level_trap_setup, 7'h1E, 7'h09);
      ws(1, 5, n);
      chk(16'(n), 16'h0001);
      chk(16'(fire_target), 16'h001E);
      far_u.pin(0, 1'b1);
      cyc(6);
      far_u.pin(0, 1'b0);
      ws(1, 10, n);
      chk(16'(n), 16'h000A);
      far_u.pin(0, 1'b1);
      cyc(6);
      exec(pptu_pkg::level_trap_setup, 7'h28, 7'h09);
      ws(0, 5, n);
      far_u.key(3);
      ws(1, 5, n);
      chk(16'(fire_target), 16'h0028);
   endtask

   task automatic t_edge;
      far_u.pin(0, 1'b0);
      cyc(6);
      exec(pptu_pkg::edge_trap_setup, 7'h32, 7'h0A);
      ws(1, 8, n);
      chk(16'(n), 16'h0008);
      chk(16'(trap_armed), 16'h0001);
      far_u.pin(0, 1'b1);
      ws(1, 10, n);
      chk(16'(n < 10), 16'h0001);
      chk(16'(fire_target), 16'h0032);
      exec(pptu_pkg::edge_trap_setup, 7'h3D, 7'h0B);
      ws(0, 5, n);
      exec(pptu_pkg::level_trap_setup, 7'h3E, 7'h0C);
      ws(0, 5, n);
      far_u.pin(0, 1'b0);
      ws(1, 10, n);
      chk(16'(fire_target), 16'h003E);
      exec(pptu_pkg::edge_trap_setup, 7'h46, 7'h0D);
      ws(0, 5, n);
      exec(pptu_pkg::trap_cancel, 7'h00, 7'h0E);
      ws(0, 5, n);
      chk(16'(trap_armed), 16'h0000);
      far_u.pin(0, 1'b1);
      ws(1, 10, n);
      chk(16'(n), 16'h000A);
      exec(pptu_pkg::level_trap_setup, 7'h50, 7'h0F);
      chk(16'(trap_armed), 16'h0001);
      run_active = 1'b0;
      cyc(1);
      chk(16'(trap_armed), 16'h0000);
      run_active = 1'b1;
   endtask

   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      cur_phase = '0;
      run_active = 1'b1;
      alarm_en = 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      rstn = 1'b1;
      cyc(6);
      chk(16'(trap_armed), 16'h0000);
      chk(16'(prog_out), 16'h0000);
      t_jumps();
      t_out_beep_pause();
      t_wait();
      t_level();
      t_edge();
      close_out();
   end
endmodule
